// file: res_regs.svh
/*
  Constants of the regulator enable sequencer: clock rate, timing figures
  and the cycle counts derived from them or given directly, reset values and field positions.
  Assumes inclusion by bare name from every file that needs a constant.
*/
`ifndef RES_REGS_SVH
`define RES_REGS_SVH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define RES_CLK_MHZ 100

// ----------------------------------------------------------------
// timing figures in their own units
// ----------------------------------------------------------------
`define RES_SHORT_TIME_US 1000
`define RES_PG_SETTLE_TIME_US 100
`define RES_DLY_UNIT_TIME_US 1000

// ----------------------------------------------------------------
// cycle counts, derived from the timing figures or given directly
// ----------------------------------------------------------------
`define RES_SHORT_CYCLES (`RES_SHORT_TIME_US * `RES_CLK_MHZ)
`define RES_PG_SETTLE_CYCLES (`RES_PG_SETTLE_TIME_US * `RES_CLK_MHZ)
`define RES_DLY_UNIT_CYCLES (`RES_DLY_UNIT_TIME_US * `RES_CLK_MHZ)
`define RES_OTP_LOAD_CYCLES 16
`define RES_RAMP_BASE_CYCLES 10

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define RES_FLAG_RST 1'b0
`define RES_OUT_RST 1'b0
`define RES_IRQ_N_RST 1'b1
`define RES_SYNC_W 14
`define RES_SYNC_SUPPLY_BIT 13
`define RES_SYNC_PIN_BIT 12

`endif

// file: res_pkg.sv
/*
  Types shared by the regulator enable sequencer modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package res_pkg;

  // per output sequencing control
  typedef struct packed {
    logic on;
    logic follow;
    logic [3:0] on_dly;
    logic [3:0] off_dly;
  } res_out_cfg_t;

  // analog comparator levels of one rail
  typedef struct packed {
    logic above_short;
    logic under_ok;
    logic over_ok;
  } res_cmp_t;

  typedef enum logic [1:0] {
    ST_LOCKOUT,
    ST_CLEAR,
    ST_LOAD,
    ST_RUN
  } res_state_t;

endpackage
`default_nettype wire

// file: res_dly.sv
/*
  One output's enable decision with pin-driven start-up and shutdown delays.
  Assumes pin_level already synchronised to clk and clr synchronous.
*/
`timescale 1ns/1ns
`default_nettype none
`include "res_regs.svh"

module res_dly #(
  parameter int CNT_W = 24,
  parameter int UNIT_CYCLES = `RES_DLY_UNIT_CYCLES
) (
  // clock and clear
  input wire logic clk,
  input wire logic clr,
  // control
  input wire res_pkg::res_out_cfg_t cfg,
  input wire logic pin_level,
  // result
  output logic out_on
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] limit;
  logic pin_mode;
  logic target;
  logic match;
  logic expired;

  function automatic logic [CNT_W-1:0] dly_cycles(input logic [3:0] code);
    dly_cycles = CNT_W'(code) * CNT_W'(UNIT_CYCLES);
  endfunction

  assign pin_mode = cfg.on & cfg.follow;
  assign target = pin_mode ? pin_level : cfg.on;
  assign limit = dly_cycles(pin_level ? cfg.on_dly : cfg.off_dly);
  assign match = (out_on == target);
  assign expired = (cnt >= limit);

  // pin returning to its old level makes match true and drops the count
  always_ff @(posedge clk) begin
    if (clr) begin
      out_on <= `RES_OUT_RST;
      cnt <= '0;
    end else if (!pin_mode) begin
      out_on <= target;
      cnt <= '0;
    end else if (match) begin
      cnt <= '0;
    end else if (expired) begin
      out_on <= target;
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking dc @(posedge clk); endclocking
  default disable iff (clr);

  a_bit_no_delay: assert property (!pin_mode ##1 !clr |-> out_on == $past(cfg.on))
    else $error("bit control was delayed");
  a_pin_cancel: assert property (pin_mode && match && !clr |=> cnt == '0)
    else $error("pending delay not cancelled");
  c_delayed_turn_on: cover property (pin_mode && pin_level && !out_on ##1 out_on);

endmodule
`default_nettype wire

// file: res_rail.sv
/*
  One regulator's short-circuit protection and power-good tracking.
  Assumes cmp synchronised to clk; clears are one-cycle write-one strobes.
*/
`timescale 1ns/1ns
`default_nettype none
`include "res_regs.svh"

module res_rail #(
  parameter int CNT_W = 24,
  parameter int SHORT_CYCLES = `RES_SHORT_CYCLES
) (
  // clock and clear
  input wire logic clk,
  input wire logic clr,
  // control
  input wire logic en_req,
  input wire res_pkg::res_cmp_t cmp,
  input wire logic window_sel,
  input wire logic valid_mask,
  input wire logic invalid_mask,
  input wire logic short_clr,
  input wire logic pg_clr,
  // result
  output logic on,
  output logic soft_start,
  output logic short_flag,
  output logic pg_flag,
  output logic pg_status
);

  logic [CNT_W-1:0] low_cnt;
  logic tripped;
  logic reached;
  logic next_trip;
  logic next_valid;
  logic rise;
  logic fall;

  // one counter covers both cases: never rising after enable, and sagging later
  assign next_trip = on & ~cmp.above_short & (low_cnt == CNT_W'(SHORT_CYCLES - 1));
  assign next_valid = on & cmp.under_ok & (~window_sel | cmp.over_ok);
  assign rise = next_valid & ~pg_status;
  assign fall = ~next_valid & pg_status;
  assign soft_start = on & ~reached;

  always_ff @(posedge clk) begin
    if (clr) begin
      on <= `RES_OUT_RST;
      tripped <= 1'b0;
      reached <= 1'b0;
      low_cnt <= '0;
    end else begin
      tripped <= en_req & (tripped | next_trip);
      on <= en_req & ~tripped & ~next_trip;
      reached <= on & (reached | cmp.above_short);
      low_cnt <= (on & ~cmp.above_short & ~next_trip) ? low_cnt + 1'b1 : '0;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (clr) begin
      short_flag <= `RES_FLAG_RST;
      pg_flag <= `RES_FLAG_RST;
      pg_status <= 1'b0;
    end else begin
      short_flag <= next_trip | (short_flag & ~short_clr);
      pg_flag <= (rise & ~valid_mask) | (fall & ~invalid_mask) | (pg_flag & ~pg_clr);
      pg_status <= next_valid;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking dc @(posedge clk); endclocking
  default disable iff (clr);

  a_short_trip: assert property (next_trip |=> !on && short_flag)
    else $error("short did not disable and flag");
  a_short_hold: assert property (short_flag && !short_clr |=> short_flag)
    else $error("short flag lost without clear");
  a_valid_edge: assert property (rise && !valid_mask |=> pg_flag && pg_status)
    else $error("valid edge did not flag");
  a_invalid_edge: assert property (fall && !invalid_mask |=> pg_flag && !pg_status)
    else $error("invalid edge did not flag");
  c_short: cover property (next_trip);

endmodule
`default_nettype wire

// file: res_top.sv
/*
  Regulator enable sequencer: enables of two bucks, two linear regulators and
  two general outputs, pin-driven delays, short and power-good flags, buck
  ramping, software and undervoltage reset sequencing.
  Assumes a register file outside that holds the settings, reloads defaults
  and one-time values on request, and strobes flag clears for one cycle.
*/
`timescale 1ns/1ns
`default_nettype none
`include "res_regs.svh"

module res_top #(
  parameter int SHORT_CYCLES = `RES_SHORT_CYCLES,
  parameter int PG_SETTLE_CYCLES = `RES_PG_SETTLE_CYCLES,
  parameter int DLY_UNIT_CYCLES = `RES_DLY_UNIT_CYCLES,
  parameter int OTP_LOAD_CYCLES = `RES_OTP_LOAD_CYCLES,
  parameter int RAMP_BASE_CYCLES = `RES_RAMP_BASE_CYCLES
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic NRST,
  // supply and enable pin
  input wire logic ANALOG_SUPPLY_OK,
  input wire logic ENABLE_PIN,
  input wire logic ENABLE_PIN_PULLDOWN_CONTROL,
  output logic ENABLE_PIN_PULLDOWN_ON,
  // buck settings
  input wire res_pkg::res_out_cfg_t [1:0] BUCK_CFG,
  input wire logic [1:0][7:0] BUCK_VOLTAGE_SETTING,
  input wire logic [1:0][2:0] BUCK_RAMP_RATE,
  input wire logic [1:0] BUCK_FORCE_FIXED_SWITCHING,
  input wire logic [1:0] BUCK_VALID_EDGE_MASK,
  input wire logic [1:0] BUCK_INVALID_EDGE_MASK,
  input wire logic BUCK_VALIDITY_WINDOW_SELECT,
  input wire logic [1:0] BUCK_SHORT_CLEAR,
  input wire logic [1:0] BUCK_PG_CLEAR,
  input wire res_pkg::res_cmp_t [1:0] BUCK_CMP,
  // linear regulator settings
  input wire res_pkg::res_out_cfg_t [1:0] LINEAR_REG_CFG,
  input wire logic [1:0][4:0] LINEAR_REG_VOLTAGE_SETTING,
  input wire logic [1:0] LINEAR_REG_VALID_EDGE_MASK,
  input wire logic [1:0] LINEAR_REG_INVALID_EDGE_MASK,
  input wire logic LINEAR_REG_VALIDITY_WINDOW_SELECT,
  input wire logic [1:0] LINEAR_REG_SHORT_CLEAR,
  input wire logic [1:0] LINEAR_REG_PG_CLEAR,
  input wire res_pkg::res_cmp_t [1:0] LINEAR_REG_CMP,
  // general outputs and software reset
  input wire res_pkg::res_out_cfg_t [1:0] GENERAL_OUTPUT_CFG,
  input wire logic SOFTWARE_RESET_TRIGGER,
  // buck results
  output logic [1:0] BUCK_ON,
  output logic [1:0] BUCK_SOFT_START,
  output logic [1:0][7:0] BUCK_VOUT_CODE,
  output logic [1:0] BUCK_FIXED_SWITCHING,
  output logic [1:0] BUCK_SHORT_FLAG,
  output logic [1:0] BUCK_POWER_GOOD_FLAG,
  output logic [1:0] BUCK_OUTPUT_VALID_STATUS,
  // linear regulator results
  output logic [1:0] LINEAR_REG_ON,
  output logic [1:0] LINEAR_REG_SOFT_START,
  output logic [1:0][4:0] LINEAR_REG_VOUT_CODE,
  output logic [1:0] LINEAR_REG_PG_SETTLING,
  output logic [1:0] LINEAR_REG_SHORT_FLAG,
  output logic [1:0] LINEAR_REG_POWER_GOOD_FLAG,
  output logic [1:0] LINEAR_REG_OUTPUT_VALID_STATUS,
  // general outputs, interrupt and reset sequencing
  output logic GENERAL_OUTPUT_0,
  output logic GENERAL_OUTPUT_1,
  output logic INTERRUPT_PIN_ACTIVE_LOW,
  output logic REGS_TO_DEFAULT,
  output logic OTP_LOAD
);

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic [`RES_SYNC_W-1:0] sync_in;
  logic [`RES_SYNC_W-1:0] sync1;
  logic [`RES_SYNC_W-1:0] sync2;
  logic supply_ok;
  logic pin_level;
  res_pkg::res_cmp_t [1:0] buck_cmp_s;
  res_pkg::res_cmp_t [1:0] ldo_cmp_s;

  assign sync_in = {ANALOG_SUPPLY_OK, ENABLE_PIN, BUCK_CMP, LINEAR_REG_CMP};

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= sync_in;
      sync2 <= sync1;
    end
  end

  assign supply_ok = sync2[`RES_SYNC_SUPPLY_BIT];
  assign pin_level = sync2[`RES_SYNC_PIN_BIT];
  assign buck_cmp_s = sync2[11:6];
  assign ldo_cmp_s = sync2[5:0];

  // ----------------------------------------------------------------
  // reset sequencing
  // ----------------------------------------------------------------
  res_pkg::res_state_t state;
  res_pkg::res_state_t next_state;
  logic [7:0] load_cnt;
  logic load_done;
  logic core_clr;
  logic sw_req;

  assign sw_req = SOFTWARE_RESET_TRIGGER & (state == res_pkg::ST_RUN);
  assign load_done = (load_cnt == 8'(OTP_LOAD_CYCLES - 1));
  assign core_clr = !NRST | (state != res_pkg::ST_RUN);

  always_comb begin
    next_state = state;
    case (state)
      res_pkg::ST_LOCKOUT: if (supply_ok) next_state = res_pkg::ST_LOAD;
      res_pkg::ST_CLEAR: next_state = res_pkg::ST_LOAD;
      res_pkg::ST_LOAD: if (load_done) next_state = res_pkg::ST_RUN;
      res_pkg::ST_RUN: if (sw_req) next_state = res_pkg::ST_CLEAR;
      default: next_state = res_pkg::ST_LOCKOUT;
    endcase
    if (!supply_ok) next_state = res_pkg::ST_LOCKOUT;
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      state <= res_pkg::ST_LOCKOUT;
      load_cnt <= '0;
      REGS_TO_DEFAULT <= 1'b1;
      OTP_LOAD <= 1'b0;
    end else begin
      state <= next_state;
      load_cnt <= (state == res_pkg::ST_LOAD) ? load_cnt + 8'h01 : 8'h00;
      REGS_TO_DEFAULT <= (next_state == res_pkg::ST_LOCKOUT) | (next_state == res_pkg::ST_CLEAR);
      OTP_LOAD <= (next_state == res_pkg::ST_LOAD);
    end
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      ENABLE_PIN_PULLDOWN_ON <= 1'b0;
    end else begin
      ENABLE_PIN_PULLDOWN_ON <= ENABLE_PIN_PULLDOWN_CONTROL;
    end
  end

  // ----------------------------------------------------------------
  // general outputs
  // ----------------------------------------------------------------
  logic [1:0] general_output_0;

  for (genvar g = 0; g < 2; g++) begin : g_gpo
    res_dly #(.UNIT_CYCLES(DLY_UNIT_CYCLES)) u_dly (
      .clk(MCLK),
      .clr(core_clr),
      .cfg(GENERAL_OUTPUT_CFG[g]),
      .pin_level(pin_level),
      .out_on(general_output_0[g])
    );
  end

  assign GENERAL_OUTPUT_0 = general_output_0[0];
  assign GENERAL_OUTPUT_1 = general_output_0[1];

  // ----------------------------------------------------------------
  // buck rails with voltage ramp
  // ----------------------------------------------------------------
  // larger rate code means a slower ramp; one code step per interval
  function automatic logic [15:0] ramp_interval(input logic [2:0] rate);
    ramp_interval = 16'(RAMP_BASE_CYCLES) << rate;
  endfunction

  logic [1:0] buck_req;
  logic [1:0] ramping;

  for (genvar b = 0; b < 2; b++) begin : g_buck
    logic [15:0] tick;
    logic [7:0] code;
    logic hold_low;

    res_dly #(.UNIT_CYCLES(DLY_UNIT_CYCLES)) u_dly (
      .clk(MCLK),
      .clr(core_clr),
      .cfg(BUCK_CFG[b]),
      .pin_level(pin_level),
      .out_on(buck_req[b])
    );

    res_rail #(.SHORT_CYCLES(SHORT_CYCLES)) u_rail (
      .clk(MCLK),
      .clr(core_clr),
      .en_req(buck_req[b]),
      .cmp(buck_cmp_s[b]),
      .window_sel(BUCK_VALIDITY_WINDOW_SELECT),
      .valid_mask(BUCK_VALID_EDGE_MASK[b]),
      .invalid_mask(BUCK_INVALID_EDGE_MASK[b]),
      .short_clr(BUCK_SHORT_CLEAR[b]),
      .pg_clr(BUCK_PG_CLEAR[b]),
      .on(BUCK_ON[b]),
      .soft_start(BUCK_SOFT_START[b]),
      .short_flag(BUCK_SHORT_FLAG[b]),
      .pg_flag(BUCK_POWER_GOOD_FLAG[b]),
      .pg_status(BUCK_OUTPUT_VALID_STATUS[b])
    );

    // code stays at zero through soft start so the climb is rate limited
    assign hold_low = core_clr | ~BUCK_ON[b] | BUCK_SOFT_START[b];
    assign ramping[b] = ~hold_low & (code != BUCK_VOLTAGE_SETTING[b]);
    assign BUCK_VOUT_CODE[b] = code;

    always_ff @(posedge MCLK) begin
      if (hold_low) begin
        code <= 8'h00;
        tick <= 16'h0000;
      end else if (!ramping[b]) begin
        tick <= 16'h0000;
      end else if (tick >= ramp_interval(BUCK_RAMP_RATE[b]) - 16'h0001) begin
        code <= (code < BUCK_VOLTAGE_SETTING[b]) ? code + 8'h01 : code - 8'h01;
        tick <= 16'h0000;
      end else begin
        tick <= tick + 16'h0001;
      end
    end

    always_ff @(posedge MCLK) begin
      if (core_clr) begin
        BUCK_FIXED_SWITCHING[b] <= 1'b0;
      end else begin
        BUCK_FIXED_SWITCHING[b] <= ramping[b] | (BUCK_ON[b] & BUCK_FORCE_FIXED_SWITCHING[b]);
      end
    end
  end

  // ----------------------------------------------------------------
  // linear rails
  // ----------------------------------------------------------------
  logic [1:0] ldo_req;

  for (genvar l = 0; l < 2; l++) begin : g_ldo
    logic [13:0] settle;
    logic [4:0] last_set;
    logic set_moved;

    res_dly #(.UNIT_CYCLES(DLY_UNIT_CYCLES)) u_dly (
      .clk(MCLK),
      .clr(core_clr),
      .cfg(LINEAR_REG_CFG[l]),
      .pin_level(pin_level),
      .out_on(ldo_req[l])
    );

    res_rail #(.SHORT_CYCLES(SHORT_CYCLES)) u_rail (
      .clk(MCLK),
      .clr(core_clr),
      .en_req(ldo_req[l]),
      .cmp(ldo_cmp_s[l]),
      .window_sel(LINEAR_REG_VALIDITY_WINDOW_SELECT),
      .valid_mask(LINEAR_REG_VALID_EDGE_MASK[l]),
      .invalid_mask(LINEAR_REG_INVALID_EDGE_MASK[l]),
      .short_clr(LINEAR_REG_SHORT_CLEAR[l]),
      .pg_clr(LINEAR_REG_PG_CLEAR[l]),
      .on(LINEAR_REG_ON[l]),
      .soft_start(LINEAR_REG_SOFT_START[l]),
      .short_flag(LINEAR_REG_SHORT_FLAG[l]),
      .pg_flag(LINEAR_REG_POWER_GOOD_FLAG[l]),
      .pg_status(LINEAR_REG_OUTPUT_VALID_STATUS[l])
    );

    assign set_moved = LINEAR_REG_ON[l] & (last_set != LINEAR_REG_VOLTAGE_SETTING[l]);
    assign LINEAR_REG_PG_SETTLING[l] = (settle != 14'h0000);

    // reference code moves with the target at once; window marks doubtful status
    always_ff @(posedge MCLK) begin
      if (core_clr) begin
        settle <= 14'h0000;
        last_set <= 5'h00;
        LINEAR_REG_VOUT_CODE[l] <= 5'h00;
      end else begin
        last_set <= LINEAR_REG_VOLTAGE_SETTING[l];
        LINEAR_REG_VOUT_CODE[l] <= LINEAR_REG_ON[l] ? LINEAR_REG_VOLTAGE_SETTING[l] : 5'h00;
        if (set_moved) begin
          settle <= 14'(PG_SETTLE_CYCLES);
        end else if (settle != 14'h0000) begin
          settle <= settle - 14'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt pin
  // ----------------------------------------------------------------
  logic any_flag;

  assign any_flag = |{BUCK_SHORT_FLAG, BUCK_POWER_GOOD_FLAG, LINEAR_REG_SHORT_FLAG, LINEAR_REG_POWER_GOOD_FLAG};

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      INTERRUPT_PIN_ACTIVE_LOW <= `RES_IRQ_N_RST;
    end else begin
      INTERRUPT_PIN_ACTIVE_LOW <= ~any_flag;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking dc @(posedge MCLK); endclocking
  default disable iff (!NRST);

  a_irq_pending: assert property (any_flag |=> !INTERRUPT_PIN_ACTIVE_LOW)
    else $error("interrupt pin released with flags pending");
  a_irq_release: assert property (!any_flag |=> INTERRUPT_PIN_ACTIVE_LOW)
    else $error("interrupt pin held with no flags");
  a_sw_all_off: assert property (sw_req && supply_ok |=> REGS_TO_DEFAULT ##1 (BUCK_ON == 2'b00)
    && (LINEAR_REG_ON == 2'b00) && !GENERAL_OUTPUT_0 && !GENERAL_OUTPUT_1)
    else $error("software reset left an output on");
  a_sw_reload: assert property (sw_req && supply_ok ##1 supply_ok |=> OTP_LOAD)
    else $error("software reset did not reload");
  a_lockout_default: assert property (!supply_ok |=> REGS_TO_DEFAULT && !OTP_LOAD)
    else $error("lockout did not default registers");
  a_por_load: assert property (state == res_pkg::ST_LOCKOUT && supply_ok |=> OTP_LOAD)
    else $error("recovery did not load one-time values");
  a_ramp_fixed: assert property (ramping[0] && !core_clr |=> BUCK_FIXED_SWITCHING[0])
    else $error("ramp without fixed switching");
  a_ldo_settle: assert property (g_ldo[0].set_moved && !core_clr |=> LINEAR_REG_PG_SETTLING[0])
    else $error("reference move not marked");

  c_software_reset_trigger: cover property (sw_req ##3 state == res_pkg::ST_LOAD);
  c_ramp_done: cover property (ramping[0] ##1 !ramping[0] && BUCK_ON[0]);
  c_irq_cycle: cover property (!INTERRUPT_PIN_ACTIVE_LOW ##1 INTERRUPT_PIN_ACTIVE_LOW);

endmodule
`default_nettype wire

// file: res_far.sv
/*
  Far-side analog model: four rail outputs (bucks 0..1, linear 2..3)
  seen through comparators. Assumes enables from the block under test.
*/
`timescale 1ns/1ns
`default_nettype none
module res_far (
  // clock
  input wire logic MCLK,
  // rail enables and fault commands
  input wire logic [3:0] rail_on,
  input wire logic [3:0] short_cmd,
  // comparator levels
  output var res_pkg::res_cmp_t [3:0] cmp
);
  logic [3:0] d1, d2;
  // output voltage lags the enable; a shorted rail never rises
  always_ff @(posedge MCLK) begin
    d1 <= rail_on & ~short_cmd;
    d2 <= d1;
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cmp[i] = {d2[i], d2[i], 1'b1};
    end
  end
endmodule
`default_nettype wire

// file: regulator_enable_sequencer_tb.sv
/*
  Self-checking bench of res_top with short delay parameters.
  Assumes res_far stands in for the rails.
*/
`timescale 1ns/1ns
`default_nettype none
module regulator_enable_sequencer_tb;
  typedef struct {string n; logic [7:0] e;} res_note_t;
  logic MCLK = 0, NRST = 0, ANALOG_SUPPLY_OK = 1, ENABLE_PIN = 0;
  logic ENABLE_PIN_PULLDOWN_CONTROL = 0, SOFTWARE_RESET_TRIGGER = 0;
  logic BUCK_VALIDITY_WINDOW_SELECT = 1, LINEAR_REG_VALIDITY_WINDOW_SELECT = 1;
  logic ENABLE_PIN_PULLDOWN_ON, GENERAL_OUTPUT_0, GENERAL_OUTPUT_1;
  logic INTERRUPT_PIN_ACTIVE_LOW, REGS_TO_DEFAULT, OTP_LOAD;
  res_pkg::res_out_cfg_t [1:0] BUCK_CFG = '0, LINEAR_REG_CFG = '0, GENERAL_OUTPUT_CFG = '0;
  res_pkg::res_cmp_t [1:0] BUCK_CMP, LINEAR_REG_CMP;
  res_pkg::res_cmp_t [3:0] cmp;
  logic [1:0][7:0] BUCK_VOLTAGE_SETTING = '0, BUCK_VOUT_CODE;
  logic [1:0][4:0] LINEAR_REG_VOLTAGE_SETTING = '0, LINEAR_REG_VOUT_CODE;
  logic [1:0][2:0] BUCK_RAMP_RATE = '0;
  logic [1:0] BUCK_FORCE_FIXED_SWITCHING = '0, BUCK_VALID_EDGE_MASK = '0, BUCK_INVALID_EDGE_MASK = '1;
  logic [1:0] BUCK_SHORT_CLEAR = '0, BUCK_PG_CLEAR = '0, LINEAR_REG_SHORT_CLEAR = '0, LINEAR_REG_PG_CLEAR = '0;
  logic [1:0] LINEAR_REG_VALID_EDGE_MASK = '1, LINEAR_REG_INVALID_EDGE_MASK = '1;
  logic [1:0] BUCK_ON, BUCK_SOFT_START, BUCK_FIXED_SWITCHING, BUCK_SHORT_FLAG, BUCK_POWER_GOOD_FLAG;
  logic [1:0] BUCK_OUTPUT_VALID_STATUS, LINEAR_REG_ON, LINEAR_REG_SOFT_START, LINEAR_REG_PG_SETTLING;
  logic [1:0] LINEAR_REG_SHORT_FLAG, LINEAR_REG_POWER_GOOD_FLAG, LINEAR_REG_OUTPUT_VALID_STATUS;
  logic [3:0] short_cmd = '0;
  logic [7:0] rnd = 8'h46;
  logic [3:0] k;
  int mismatches = 0, checked = 0;
  res_note_t notes[$];
  event look;
  always #5 MCLK = ~MCLK;
  assign BUCK_CMP = cmp[1:0];
  assign LINEAR_REG_CMP = cmp[3:2];
  res_top #(.SHORT_CYCLES(20), .PG_SETTLE_CYCLES(8), .DLY_UNIT_CYCLES(5)) res_top_i (
    .MCLK, .NRST, .ANALOG_SUPPLY_OK, .ENABLE_PIN, .ENABLE_PIN_PULLDOWN_CONTROL, .ENABLE_PIN_PULLDOWN_ON,
    .BUCK_CFG, .BUCK_VOLTAGE_SETTING, .BUCK_RAMP_RATE, .BUCK_FORCE_FIXED_SWITCHING, .BUCK_VALID_EDGE_MASK,
    .BUCK_INVALID_EDGE_MASK, .BUCK_VALIDITY_WINDOW_SELECT, .BUCK_SHORT_CLEAR, .BUCK_PG_CLEAR, .BUCK_CMP,
    .LINEAR_REG_CFG, .LINEAR_REG_VOLTAGE_SETTING, .LINEAR_REG_VALID_EDGE_MASK, .LINEAR_REG_INVALID_EDGE_MASK,
    .LINEAR_REG_VALIDITY_WINDOW_SELECT, .LINEAR_REG_SHORT_CLEAR, .LINEAR_REG_PG_CLEAR, .LINEAR_REG_CMP,
    .GENERAL_OUTPUT_CFG, .SOFTWARE_RESET_TRIGGER, .BUCK_ON, .BUCK_SOFT_START, .BUCK_VOUT_CODE,
    .BUCK_FIXED_SWITCHING, .BUCK_SHORT_FLAG, .BUCK_POWER_GOOD_FLAG, .BUCK_OUTPUT_VALID_STATUS,
    .LINEAR_REG_ON, .LINEAR_REG_SOFT_START, .LINEAR_REG_VOUT_CODE, .LINEAR_REG_PG_SETTLING,
    .LINEAR_REG_SHORT_FLAG, .LINEAR_REG_POWER_GOOD_FLAG, .LINEAR_REG_OUTPUT_VALID_STATUS,
    .GENERAL_OUTPUT_0, .GENERAL_OUTPUT_1, .INTERRUPT_PIN_ACTIVE_LOW, .REGS_TO_DEFAULT, .OTP_LOAD);
  res_far res_far_i (.MCLK, .rail_on({LINEAR_REG_ON, BUCK_ON}), .short_cmd, .cmp);
  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic cyc(int n);
    repeat (n) @(negedge MCLK);
  endtask
  task automatic chk(string n, logic [7:0] e);
    notes.push_back('{n, e});
    ->look;
  endtask
  // ----------------------------------------------------------------
  // watcher: takes the oldest note and compares it with the outputs
  // ----------------------------------------------------------------
  // several notes may arrive in one time step; drain them all
  always @(look) begin
    res_note_t t;
    logic [7:0] o;
    while (notes.size() > 0) begin
      t = notes.pop_front();
      case (t.n)
        "bon0": o = 8'(BUCK_ON[0]);
        "soft0": o = 8'(BUCK_SOFT_START[0]);
        "code0": o = BUCK_VOUT_CODE[0];
        "fix0": o = 8'(BUCK_FIXED_SWITCHING[0]);
        "st0": o = 8'(BUCK_OUTPUT_VALID_STATUS[0]);
        "pg0": o = 8'(BUCK_POWER_GOOD_FLAG[0]);
        "lon0": o = 8'(LINEAR_REG_ON[0]);
        "lsc0": o = 8'(LINEAR_REG_SHORT_FLAG[0]);
        "lcode0": o = 8'(LINEAR_REG_VOUT_CODE[0]);
        "lset0": o = 8'(LINEAR_REG_PG_SETTLING[0]);
        "lst0": o = 8'(LINEAR_REG_OUTPUT_VALID_STATUS[0]);
        "gpo0": o = 8'(GENERAL_OUTPUT_0);
        "gpo1": o = 8'(GENERAL_OUTPUT_1);
        "irq_n": o = 8'(INTERRUPT_PIN_ACTIVE_LOW);
        "pd": o = 8'(ENABLE_PIN_PULLDOWN_ON);
        "otp": o = 8'(OTP_LOAD);
        default: o = 8'(REGS_TO_DEFAULT);
      endcase
      checked++;
      if (o !== t.e) begin
        mismatches++;
        $display("[ERR] %s expected %h seen %h", t.n, t.e, o);
      end
    end
  end
  task automatic end_of_test;
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end
  initial begin
    cyc(12); NRST = 1; cyc(40);
    ENABLE_PIN_PULLDOWN_CONTROL = 1; cyc(3); chk("pd", 1);
    BUCK_CFG[0].on = 1; BUCK_VOLTAGE_SETTING[0] = 8'h03; cyc(2); chk("bon0", 1);
    chk("soft0", 1);
    chk("code0", 8'h00);
    cyc(8); chk("fix0", 1);
    chk("soft0", 0);
    cyc(60); chk("code0", 8'h03);
    chk("fix0", 0);
    chk("st0", 1);
    chk("pg0", 1);
    chk("irq_n", 0);
    BUCK_PG_CLEAR[0] = 1; cyc(1); BUCK_PG_CLEAR[0] = 0; cyc(3); chk("pg0", 0);
    short_cmd[2] = 1; LINEAR_REG_CFG[0].on = 1; cyc(2); chk("lon0", 1);
    cyc(40); chk("lon0", 0);
    chk("lsc0", 1);
    chk("irq_n", 0);
    LINEAR_REG_CFG[0].on = 0; short_cmd = '0;
    LINEAR_REG_SHORT_CLEAR[0] = 1; cyc(1); LINEAR_REG_SHORT_CLEAR[0] = 0; cyc(3); chk("lsc0", 0);
    chk("irq_n", 1);
    LINEAR_REG_CFG[0].on = 1; cyc(3); LINEAR_REG_VOLTAGE_SETTING[0] = 5'h05; cyc(1); chk("lcode0", 8'h05);
    chk("lset0", 1);
    cyc(7); chk("lset0", 1);
    cyc(1); chk("lset0", 0);
    chk("lst0", 1);
    GENERAL_OUTPUT_CFG[1] = {1'b1, 1'b0, 4'hf, 4'hf}; cyc(2); chk("gpo1", 1);
    rnd = lfsr(rnd); k = {2'b00, rnd[1:0]} + 4'h1;
    GENERAL_OUTPUT_CFG[0] = {1'b1, 1'b1, k, 4'h1};
    ENABLE_PIN = 1; cyc(4); ENABLE_PIN = 0; cyc(30); chk("gpo0", 0);
    ENABLE_PIN = 1; cyc(k * 5 + 2); chk("gpo0", 0);
    cyc(1); chk("gpo0", 1);
    ENABLE_PIN = 0; cyc(7); chk("gpo0", 1);
    cyc(1); chk("gpo0", 0);
    SOFTWARE_RESET_TRIGGER = 1; cyc(1); SOFTWARE_RESET_TRIGGER = 0; chk("def", 1);
    cyc(2); chk("otp", 1);
    chk("bon0", 0);
    chk("gpo1", 0);
    cyc(40); chk("bon0", 1);
    ANALOG_SUPPLY_OK = 0; cyc(5); chk("def", 1);
    chk("bon0", 0);
    chk("gpo1", 0);
    cyc(2);
    end_of_test();
  end
endmodule
`default_nettype wire
